// ==== rtl/can_node_consts.svh ====
`ifndef CAN_NODE_CONSTS_SVH
`define CAN_NODE_CONSTS_SVH
// Overview of operation
// R1: data frame: 11-bit identifier, zero to eight bytes
// R2: remote frame has no data, requests owner's frame
// R3: smallest identifier wins; losers stop transmitting
// R4: only standard frames accepted, extended frames ignored
// R5: errors raise counters, successful frames lower them
// R6: low counters: error-active, errors signalled dominantly
// R7: above first limit: warning state, still operating
// R8: above second limit: passive, no active flags
// R9: bus-off: neither transmit nor receive anything
// R10: detect protocol errors and flag them on bus
// R11: node address 1 to 127, unique
// R12: frames name content; any node may consume them
// R13: data kept as indexed dictionary of objects
// R14: multi-byte values sent least significant byte first
// R15: identifier: function code bits 10-7, address below
// R16: usual thresholds 96/128/256 and 128x11 recovery

`define ID_W 11
`define FUNC_W 4
`define ADDR_W 7
`define DLC_W 4
`define MAX_DLC 4'h8
`define CRC_POLY 15'h4599
`define CRC_LAST 7'h0e
`define ID_LAST 7'h0a
`define CTRL_LAST 7'h06
`define EOF_LAST 7'h06
`define FLAG_LAST 7'h05
`define IDLE_BITS 11
`define INTERMISSION_BITS 3
`define WARN_LIMIT 9'h060
`define PASSIVE_LIMIT 9'h080
`define BUSOFF_LIMIT 9'h100
`define TEC_ERR_STEP 9'h008
`define RECOVERY_SEQS 128
`define CLK_PERIOD_NS 20
`define BIT_TIME_NS 2000
`define BIT_CYCLES ((`BIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DICT_DEPTH 16
`define INDEX_W 4

`endif

// ==== rtl/can_node_pkg.sv ====
package can_node_pkg;

    // fault confinement level of the node
    typedef enum logic [1:0] {ERR_ACTIVE, ERR_WARNING, ERR_PASSIVE, ERR_BUS_OFF} err_state_t;

    // frame field currently on the bus
    typedef enum logic [3:0] {
        F_IDLE, F_ID, F_CTRL, F_DATA, F_CRC, F_CRC_DELIM, F_ACK, F_ACK_DELIM,
        F_EOF, F_ERR_FLAG, F_WAIT
    } field_t;

endpackage : can_node_pkg

// ==== rtl/can_err_counter.sv ====
`timescale 1ns/1ps
`include "can_node_consts.svh"

module can_err_counter (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_bit_en,
    input wire logic i_rx,
    input wire logic i_tx_err,
    input wire logic i_rx_err,
    input wire logic i_tx_ok,
    input wire logic i_rx_ok,
    output logic [8:0] o_tec,
    output logic [8:0] o_rec,
    output can_node_pkg::err_state_t o_err_state
);
    import can_node_pkg::*;

    logic [3:0] idle_run_q;
    logic [7:0] seq_q;
    logic run_done;
    logic recover;

    // bus-off recovery: 128 runs of 11 recessive bits
    assign run_done = i_bit_en && i_rx && (idle_run_q == 4'(`IDLE_BITS - 1));
    assign recover = (o_err_state == ERR_BUS_OFF) && run_done
        && (seq_q == 8'(`RECOVERY_SEQS - 1)); // [R16]

    // transmit counter, frozen while off the bus
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_tec <= 9'h000;
        else if (recover)
            o_tec <= 9'h000; // [R16]
        else if (o_err_state != ERR_BUS_OFF)
        begin
            if (i_tx_err)
                o_tec <= o_tec + `TEC_ERR_STEP; // [R5]
            else if (i_tx_ok && o_tec != 9'h000)
                o_tec <= o_tec - 9'h001; // [R5]
        end
    end

    // receive counter, saturating so it cannot wrap to a low level
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rec <= 9'h000;
        else if (recover)
            o_rec <= 9'h000;
        else if (o_err_state != ERR_BUS_OFF)
        begin
            if (i_rx_err && o_rec != 9'h0ff)
                o_rec <= o_rec + 9'h001; // [R5]
            else if (i_rx_ok && o_rec != 9'h000)
                o_rec <= o_rec - 9'h001; // [R5]
        end
    end

    // confinement state, bus-off sticky until recovery
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_err_state <= ERR_ACTIVE;
        else if (recover)
            o_err_state <= ERR_ACTIVE;
        else if (o_err_state == ERR_BUS_OFF)
            o_err_state <= ERR_BUS_OFF;
        else if (o_tec >= `BUSOFF_LIMIT)
            o_err_state <= ERR_BUS_OFF; // [R16]
        else if (o_tec >= `PASSIVE_LIMIT || o_rec >= `PASSIVE_LIMIT)
            o_err_state <= ERR_PASSIVE; // [R8]
        else if (o_tec >= `WARN_LIMIT || o_rec >= `WARN_LIMIT)
            o_err_state <= ERR_WARNING; // [R7]
        else
            o_err_state <= ERR_ACTIVE; // [R6]
    end

    // recessive run and sequence counters, only used while off
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            idle_run_q <= 4'h0;
            seq_q <= 8'h00;
        end
        else if (o_err_state != ERR_BUS_OFF)
        begin
            idle_run_q <= 4'h0;
            seq_q <= 8'h00;
        end
        else if (i_bit_en)
        begin
            idle_run_q <= (!i_rx || run_done) ? 4'h0 : idle_run_q + 4'h1;
            if (run_done)
                seq_q <= seq_q + 8'h01;
        end
    end

    tec_step_a: assert property ( // [R5]
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_tx_err && o_err_state != ERR_BUS_OFF) |=> (o_tec == $past(o_tec) + 9'h008))
        else $error("transmit counter did not rise by eight");

    warn_level_a: assert property ( // [R7]
        @(posedge i_clock) disable iff (!i_rst_n)
        (o_err_state == ERR_WARNING) |->
        (($past(o_tec) >= 9'h060 || $past(o_rec) >= 9'h060)
        && $past(o_tec) < 9'h080 && $past(o_rec) < 9'h080))
        else $error("warning state without matching counter level");

    passive_level_a: assert property ( // [R8]
        @(posedge i_clock) disable iff (!i_rst_n)
        (o_err_state == ERR_PASSIVE) |-> ($past(o_tec) >= 9'h080 || $past(o_rec) >= 9'h080))
        else $error("passive state without counter above limit");

    busoff_entry_a: assert property ( // [R16]
        @(posedge i_clock) disable iff (!i_rst_n)
        (o_tec >= 9'h100 && o_err_state != ERR_BUS_OFF) |=> (o_err_state == ERR_BUS_OFF))
        else $error("counter above bus-off limit but node still on bus");

endmodule : can_err_counter

// ==== rtl/can_frame_error_node.sv ====
`timescale 1ns/1ps
`include "can_node_consts.svh"

module can_frame_error_node #(
    parameter int BIT_CYCLES = `BIT_CYCLES,
    parameter int DICT_DEPTH = `DICT_DEPTH,
    parameter int INDEX_W = `INDEX_W
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_rx,
    input wire logic [`ADDR_W-1:0] i_node_addr,
    input wire logic i_dict_we,
    input wire logic [INDEX_W-1:0] i_dict_index,
    input wire logic [63:0] i_dict_wdata,
    input wire logic i_tx_req,
    input wire logic [`FUNC_W-1:0] i_tx_func,
    input wire logic [INDEX_W-1:0] i_tx_index,
    input wire logic [`DLC_W-1:0] i_tx_dlc,
    input wire logic i_tx_rtr,
    input wire logic [`FUNC_W-1:0] i_reply_func,
    input wire logic [INDEX_W-1:0] i_reply_index,
    input wire logic [`DLC_W-1:0] i_reply_dlc,
    output logic o_tx,
    output logic o_tx_busy,
    output logic o_tx_done,
    output logic o_rx_valid,
    output logic [`ID_W-1:0] o_rx_id,
    output logic o_rx_rtr,
    output logic [`DLC_W-1:0] o_rx_dlc,
    output logic [63:0] o_rx_data,
    output logic o_addr_fault,
    output can_node_pkg::err_state_t o_err_state,
    output logic [8:0] o_tec,
    output logic [8:0] o_rec
);
    import can_node_pkg::*;

    localparam int DIV_W = $clog2(BIT_CYCLES);

    // refuse sizes the logic cannot serve
    if (BIT_CYCLES < 4 || DICT_DEPTH < 1 || DICT_DEPTH > (2 ** INDEX_W))
    begin : g_bad_param
        $error("unsupported bit time or dictionary size");
    end

    // longer frames are clamped; a count above eight still means eight bytes
    function automatic logic [3:0] clamp_dlc(input logic [3:0] d);
        clamp_dlc = (d > `MAX_DLC) ? `MAX_DLC : d; // [R1]
    endfunction : clamp_dlc

    function automatic logic [14:0] crc_step(input logic [14:0] c, input logic b);
        crc_step = {c[13:0], 1'b0} ^ ((b ^ c[14]) ? `CRC_POLY : 15'h0000);
    endfunction : crc_step

    logic [DIV_W-1:0] div_q;
    logic bit_en_q;
    logic [63:0] dict_mem [DICT_DEPTH];
    logic [`ID_W-1:0] pend_id_q;
    logic pend_rtr_q;
    logic [3:0] pend_dlc_q;
    logic [63:0] pend_data_q;
    logic reply_q;
    field_t fld_q, fld_d;
    logic [6:0] cnt_q, cnt_d;
    logic tx_act_q, tx_act_d;
    logic wait_short_q, wait_short_d;
    logic [14:0] crc_q, crc_d;
    logic crc_bad_q;
    logic [`ID_W-1:0] rx_id_q;
    logic rx_rtr_q;
    logic [3:0] rx_dlc_q;
    logic [63:0] rx_data_q;
    logic tx_d, err_now, lose, skip, frame_ok, start, bus_off;
    logic [3:0] dlc_now;
    logic tx_err, rx_err, tx_ok, rx_ok;

    // bit-rate enable; no resync to edges, so nodes must share a tight clock
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            div_q <= '0;
            bit_en_q <= 1'b0;
        end
        else
        begin
            bit_en_q <= (div_q == DIV_W'(BIT_CYCLES - 1));
            div_q <= (div_q == DIV_W'(BIT_CYCLES - 1)) ? '0 : div_q + DIV_W'(1);
        end
    end

    // object dictionary, one eight-byte object per index
    always_ff @(posedge i_clock)
    begin
        if (i_dict_we && int'(i_dict_index) < DICT_DEPTH)
            dict_mem[i_dict_index] <= i_dict_wdata; // [R13]
    end

    // address 0 is reserved for the master; such a slave never starts a frame of its own
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_addr_fault <= 1'b1;
        else
            o_addr_fault <= (i_node_addr == 7'h00); // [R11]
    end

    // pending frame; retried after loss or error until it succeeds
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_tx_busy <= 1'b0;
            pend_id_q <= '0;
            pend_rtr_q <= 1'b0;
            pend_dlc_q <= 4'h0;
            pend_data_q <= 64'h0;
        end
        else if (tx_ok)
            o_tx_busy <= 1'b0;
        else if (!o_tx_busy && i_tx_req)
        begin
            o_tx_busy <= 1'b1;
            pend_id_q <= {i_tx_func, i_node_addr}; // [R15]
            pend_rtr_q <= i_tx_rtr; // [R2]
            pend_dlc_q <= clamp_dlc(i_tx_dlc);
            pend_data_q <= i_tx_rtr ? 64'h0 : dict_mem[i_tx_index]; // [R13]
        end
        else if (!o_tx_busy && reply_q)
        begin
            o_tx_busy <= 1'b1;
            pend_id_q <= {i_reply_func, i_node_addr}; // [R15]
            pend_rtr_q <= 1'b0;
            pend_dlc_q <= clamp_dlc(i_reply_dlc);
            pend_data_q <= dict_mem[i_reply_index]; // [R2]
        end
    end

    // remote request for our reply object; set wins over the load
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            reply_q <= 1'b0;
        else if (rx_ok && rx_rtr_q && !o_addr_fault && rx_id_q == {i_reply_func, i_node_addr})
            reply_q <= 1'b1; // [R2]
        else if (!o_tx_busy && !i_tx_req)
            reply_q <= 1'b0;
    end

    // frame sequencing and error detection, one decision per bit
    always_comb
    begin
        fld_d = fld_q;
        cnt_d = cnt_q + 7'h01;
        tx_act_d = tx_act_q;
        wait_short_d = wait_short_q;
        err_now = 1'b0;
        lose = 1'b0;
        skip = 1'b0;
        frame_ok = 1'b0;
        bus_off = (o_err_state == ERR_BUS_OFF);
        dlc_now = clamp_dlc({rx_dlc_q[2:0], i_rx});
        start = (fld_q == F_IDLE) && i_rx && o_tx_busy && !o_addr_fault && !bus_off;
        case (fld_q)
            F_IDLE:
            begin
                cnt_d = 7'h00;
                if (!i_rx && !bus_off) // [R9]
                begin
                    fld_d = F_ID;
                    tx_act_d = !o_tx;
                end
            end
            F_ID, F_CTRL:
            begin
                if (fld_q == F_CTRL && cnt_q == 7'h01 && i_rx && !tx_act_q)
                    skip = 1'b1; // [R4]
                else if (tx_act_q && o_tx && !i_rx && (fld_q == F_ID || cnt_q == 7'h00))
                    lose = 1'b1; // [R3]
                else if (tx_act_q && o_tx != i_rx)
                    err_now = 1'b1; // [R10]
                if (fld_q == F_ID && cnt_q == `ID_LAST)
                begin
                    fld_d = F_CTRL;
                    cnt_d = 7'h00;
                end
                else if (fld_q == F_CTRL && cnt_q == `CTRL_LAST)
                begin
                    fld_d = (rx_rtr_q || dlc_now == 4'h0) ? F_CRC : F_DATA; // [R2]
                    cnt_d = 7'h00;
                end
            end
            F_DATA, F_CRC:
            begin
                if (tx_act_q && o_tx != i_rx)
                    err_now = 1'b1; // [R10]
                if (fld_q == F_DATA && cnt_q == {rx_dlc_q, 3'h7} - 7'h08)
                begin
                    fld_d = F_CRC;
                    cnt_d = 7'h00;
                end
                else if (fld_q == F_CRC && cnt_q == `CRC_LAST)
                    fld_d = F_CRC_DELIM;
            end
            F_CRC_DELIM:
            begin
                err_now = !i_rx || (!tx_act_q && crc_bad_q); // [R10]
                fld_d = F_ACK;
            end
            F_ACK:
            begin
                err_now = tx_act_q && i_rx; // [R10]
                fld_d = F_ACK_DELIM;
            end
            F_ACK_DELIM, F_EOF:
            begin
                err_now = !i_rx; // [R10]
                if (fld_q == F_ACK_DELIM)
                begin
                    fld_d = F_EOF;
                    cnt_d = 7'h00;
                end
                else if (cnt_q == `EOF_LAST)
                begin
                    frame_ok = 1'b1;
                    fld_d = F_WAIT;
                    cnt_d = 7'h00;
                    wait_short_d = 1'b1;
                end
            end
            F_ERR_FLAG:
            begin
                if (cnt_q == `FLAG_LAST)
                begin
                    fld_d = F_WAIT;
                    cnt_d = 7'h00;
                    wait_short_d = 1'b0;
                end
            end
            F_WAIT:
            begin
                if (!i_rx && wait_short_q && !bus_off)
                begin
                    fld_d = F_ID; // a dominant bit during intermission is taken as another node's start bit
                    cnt_d = 7'h00;
                    tx_act_d = 1'b0;
                end
                else if (!i_rx)
                    cnt_d = 7'h00;
                else if (cnt_q == (wait_short_q ? 7'(`INTERMISSION_BITS - 1)
                                                : 7'(`IDLE_BITS - 1)))
                    fld_d = F_IDLE;
            end
            default:
                fld_d = F_IDLE;
        endcase
        if (lose)
            tx_act_d = 1'b0; // [R3]
        if (frame_ok)
            tx_act_d = 1'b0;
        if (skip)
        begin
            fld_d = F_WAIT;
            cnt_d = 7'h00;
            wait_short_d = 1'b0;
        end
        if (err_now)
        begin
            fld_d = F_ERR_FLAG;
            cnt_d = 7'h00;
            tx_act_d = 1'b0;
        end
    end

    // crc runs over the bus level from start bit to data end
    always_comb
    begin
        case (fld_q)
            F_ID, F_CTRL, F_DATA: crc_d = crc_step(crc_q, i_rx);
            F_IDLE, F_WAIT: crc_d = 15'h0000;
            default: crc_d = crc_q;
        endcase
    end

    // level to drive during the next bit
    always_comb
    begin
        case (fld_d)
            F_IDLE: tx_d = !start;
            F_ID: tx_d = !tx_act_d || pend_id_q[4'ha - cnt_d[3:0]]; // [R3]
            F_CTRL:
                if (!tx_act_d)
                    tx_d = 1'b1;
                else if (cnt_d == 7'h00)
                    tx_d = pend_rtr_q;
                else if (cnt_d < 7'h03)
                    tx_d = 1'b0; // [R4]
                else
                    tx_d = pend_dlc_q[2'(7'h06 - cnt_d)];
            F_DATA: tx_d = !tx_act_d || pend_data_q[{cnt_d[5:3], ~cnt_d[2:0]}]; // [R14]
            F_CRC: tx_d = !tx_act_d || crc_d[4'he - cnt_d[3:0]];
            F_ACK: tx_d = tx_act_d || crc_bad_q || bus_off;
            F_ERR_FLAG: tx_d = (o_err_state == ERR_PASSIVE) || bus_off; // [R6] [R8]
            default: tx_d = 1'b1;
        endcase
    end

    assign tx_err = bit_en_q && err_now && tx_act_q;
    assign rx_err = bit_en_q && err_now && !tx_act_q;
    assign tx_ok = bit_en_q && frame_ok && tx_act_q;
    assign rx_ok = bit_en_q && frame_ok && !tx_act_q;

    // frame state, advanced once per bit
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            fld_q <= F_WAIT; // join only after an idle bus is seen
            cnt_q <= 7'h00;
            tx_act_q <= 1'b0;
            wait_short_q <= 1'b0;
            crc_q <= 15'h0000;
            o_tx <= 1'b1;
        end
        else if (bit_en_q)
        begin
            fld_q <= fld_d;
            cnt_q <= cnt_d;
            tx_act_q <= tx_act_d;
            wait_short_q <= wait_short_d;
            crc_q <= crc_d;
            o_tx <= tx_d;
        end
    end

    // capture of the received fields
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_id_q <= '0;
            rx_rtr_q <= 1'b0;
            rx_dlc_q <= 4'h0;
            rx_data_q <= 64'h0;
            crc_bad_q <= 1'b0;
        end
        else if (bit_en_q)
        begin
            case (fld_q)
                F_IDLE, F_WAIT:
                begin
                    rx_data_q <= 64'h0;
                    crc_bad_q <= 1'b0;
                end
                F_ID: rx_id_q <= {rx_id_q[9:0], i_rx};
                F_CTRL:
                    if (cnt_q == 7'h00)
                        rx_rtr_q <= i_rx;
                    else if (cnt_q >= 7'h03)
                        rx_dlc_q <= (cnt_q == `CTRL_LAST) ? dlc_now : {rx_dlc_q[2:0], i_rx};
                F_DATA: rx_data_q[{cnt_q[5:3], ~cnt_q[2:0]}] <= i_rx; // [R14]
                F_CRC:
                    if (i_rx != crc_q[4'he - cnt_q[3:0]])
                        crc_bad_q <= 1'b1;
                default: crc_bad_q <= crc_bad_q;
            endcase
        end
    end

    // every good frame from others is offered; the user filters by content
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rx_valid <= 1'b0;
            o_tx_done <= 1'b0;
            o_rx_id <= '0;
            o_rx_rtr <= 1'b0;
            o_rx_dlc <= 4'h0;
            o_rx_data <= 64'h0;
        end
        else
        begin
            o_rx_valid <= rx_ok; // [R12]
            o_tx_done <= tx_ok;
            if (rx_ok)
            begin
                o_rx_id <= rx_id_q; // [R1]
                o_rx_rtr <= rx_rtr_q;
                o_rx_dlc <= rx_dlc_q;
                o_rx_data <= rx_data_q;
            end
        end
    end

    can_err_counter u_err (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_bit_en(bit_en_q),
        .i_rx(i_rx),
        .i_tx_err(tx_err),
        .i_rx_err(rx_err),
        .i_tx_ok(tx_ok),
        .i_rx_ok(rx_ok),
        .o_tec(o_tec),
        .o_rec(o_rec),
        .o_err_state(o_err_state)
    );

    arb_loss_a: assert property ( // [R3]
        @(posedge i_clock) disable iff (!i_rst_n)
        (bit_en_q && lose) |=> (!tx_act_q && o_tx))
        else $error("node kept driving after losing arbitration");

    ext_reject_a: assert property ( // [R4]
        @(posedge i_clock) disable iff (!i_rst_n)
        (bit_en_q && fld_q == F_CTRL && cnt_q == 7'h01 && i_rx && !tx_act_q)
        |=> (fld_q == F_WAIT && !o_rx_valid))
        else $error("extended frame was not dropped");

    busoff_quiet_a: assert property ( // [R9]
        @(posedge i_clock) disable iff (!i_rst_n)
        (o_err_state == ERR_BUS_OFF && fld_q != F_ERR_FLAG) |-> (o_tx && !o_rx_valid))
        else $error("bus-off node touched the bus");

    active_flag_a: assert property ( // [R10]
        @(posedge i_clock) disable iff (!i_rst_n)
        (bit_en_q && err_now && (o_err_state == ERR_ACTIVE || o_err_state == ERR_WARNING))
        |=> (!o_tx && fld_q == F_ERR_FLAG))
        else $error("active node did not drive a dominant error flag");

    passive_flag_a: assert property ( // [R8]
        @(posedge i_clock) disable iff (!i_rst_n)
        (bit_en_q && err_now && o_err_state == ERR_PASSIVE) |=> o_tx)
        else $error("passive node drove a dominant error flag");

    addr_guard_a: assert property ( // [R11]
        @(posedge i_clock) disable iff (!i_rst_n)
        (bit_en_q && fld_q == F_IDLE && i_rx && o_addr_fault) |=> o_tx)
        else $error("node with invalid address started a frame");

    tx_done_c: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_tx_done);
    arb_lost_c: cover property (@(posedge i_clock) disable iff (!i_rst_n) bit_en_q && lose);
    rx_frame_c: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_rx_valid);
    bus_off_c: cover property (@(posedge i_clock) disable iff (!i_rst_n)
        o_err_state == ERR_BUS_OFF);

endmodule : can_frame_error_node

// ==== dv/can_bus_peer.sv ====
`timescale 1ns/1ps
module can_bus_peer #(
    parameter int BC = 4
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_bus,
    input wire logic [7:0] i_ack_bit,
    output logic o_drv
);
    logic [127:0] seen;
    logic [127:0] bits;
    int len = 0, pos = 0;
    int cnt, run, idx, n_i;
    // same bit grid as the node; a released line rests recessive
    always @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt <= BC - 1; // acts on the same edges as the node's bit enable
            run <= 0;
            idx <= 200;
            o_drv <= 1'b1;
        end
        else if (cnt == BC - 1)
        begin
            cnt <= 0;
            run <= i_bus ? run + 1 : 0;
            n_i = (run >= 10 && !i_bus) ? 0 : idx + 1; // start of frame
            idx <= n_i;
            if (n_i < 128)
                seen[n_i] <= i_bus;
            o_drv <= (pos < len) ? bits[pos] : (n_i + 1 != int'(i_ack_bit)); // ack
            if (pos < len)
                pos <= pos + 1;
        end
        else
            cnt <= cnt + 1;
    end
    // starts only after an idle bus, else the node would miss the start bit
    task automatic send(input logic [127:0] b, input int n);
        wait (run >= 12);
        bits = b;
        pos = 0;
        len = n;
        wait (pos >= len);
    endtask : send
endmodule : can_bus_peer

// ==== dv/can_frame_error_node_tb_top.sv ====
`timescale 1ns/1ps
module can_frame_error_node_tb_top;
    import can_node_pkg::*;
    localparam int BC = 4;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic [6:0] addr = 7'h01;
    logic we = 1'b0, req = 1'b0, rtr = 1'b0;
    logic [3:0] dlc = 4'h2, oix = 4'h1;
    logic [7:0] ack_bit = 8'h00;
    logic o_tx, busy, done, rx_ok, rx_rtr, fault, drv;
    logic [10:0] rx_id;
    logic [3:0] rx_dlc;
    logic [63:0] rx_data;
    logic [8:0] tec;
    err_state_t st;
    logic [127:0] fb;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_rx = 0;
    int len;
    wire bus = o_tx & drv;
    // clock and count of received frames
    always #10 i_clock = ~i_clock;
    always @(posedge i_clock)
        if (rx_ok === 1'b1)
            n_rx <= n_rx + 1;
    can_frame_error_node #(.BIT_CYCLES(BC)) uut (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_rx(bus), .i_node_addr(addr), .i_dict_we(we), .i_dict_index(oix),
        .i_dict_wdata(64'h0201), .i_tx_req(req), .i_tx_func(4'h3), .i_tx_index(oix),
        .i_tx_dlc(dlc), .i_tx_rtr(rtr), .i_reply_func(4'h5), .i_reply_index(4'h1),
        .i_reply_dlc(4'h1), .o_tx(o_tx), .o_tx_busy(busy), .o_tx_done(done),
        .o_rx_valid(rx_ok), .o_rx_id(rx_id), .o_rx_rtr(rx_rtr), .o_rx_dlc(rx_dlc),
        .o_rx_data(rx_data), .o_addr_fault(fault), .o_err_state(st), .o_tec(tec), .o_rec());
    can_bus_peer #(.BC(BC)) peer (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus(bus),
        .i_ack_bit(ack_bit), .o_drv(drv));
    task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    task automatic clk(input int n);
        repeat (n) @(posedge i_clock);
        #2;
    endtask : clk
    // bounded waits: a hang counts as a mismatch
    task automatic wait_done();
        for (int i = 0; i < 20000 && done !== 1'b1; i++)
            clk(1);
        cmp("done", 1, done);
    endtask : wait_done
    task automatic wait_st(input err_state_t s);
        for (int i = 0; i < 20000 && st !== s; i++)
            clk(1);
        cmp("state", s, st);
    endtask : wait_st
    // field of the last frame on the wire, first bit as msb
    function automatic logic [63:0] fld(input int s, input int w);
        fld = '0;
        for (int i = 0; i < w; i++)
            fld[w - 1 - i] = peer.seen[s + i];
    endfunction : fld
    // expected frame bits: header and crc msb first, data byte 0 first
    function automatic int build(input logic [10:0] id, input logic rtr, input logic ide,
        input logic [3:0] n, input logic [63:0] d);
        logic [18:0] hdr;
        logic [14:0] crc;
        int nd;
        hdr = {1'b0, id, rtr, ide, 1'b0, n};
        crc = '0;
        fb = '1;
        nd = rtr ? 0 : 8 * n;
        for (int i = 0; i < 19 + nd; i++)
        begin
            fb[i] = (i < 19) ? hdr[18 - i] : d[8 * ((i - 19) / 8) + 7 - (i - 19) % 8];
            crc = {crc[13:0], 1'b0} ^ ((fb[i] ^ crc[14]) ? 15'h4599 : 15'h0000);
        end
        for (int i = 0; i < 15; i++)
            fb[19 + nd + i] = crc[14 - i];
        return 44 + nd;
    endfunction : build
    task automatic t_reset();
        cmp("tx", 1, o_tx);
        cmp("state", ERR_ACTIVE, st);
        addr = 7'h00;
        clk(2);
        cmp("fault", 1, fault);
        addr = 7'h01;
        clk(2);
        cmp("fault", 0, fault);
        $display("test reset done");
    endtask : t_reset
    task automatic t_tx();
        we = 1'b1;
        clk(1);
        we = 1'b0;
        ack_bit = 8'd51;
        req = 1'b1;
        clk(1);
        req = 1'b0;
        cmp("busy", 1, busy);
        wait_done();
        cmp("id", 11'h181, fld(1, 11));
        cmp("byte0", 8'h01, fld(19, 8));
        cmp("byte1", 8'h02, fld(27, 8));
        cmp("tec", 0, tec);
        $display("test transmit done");
    endtask : t_tx
    task automatic t_rx();
        ack_bit = 8'd0;
        len = build(11'h201, 1'b0, 1'b0, 4'h2, 64'hbeef);
        peer.send(fb, len);
        clk(6 * BC);
        cmp("rx count", 1, n_rx);
        cmp("rx id", 11'h201, rx_id);
        cmp("rx data", 64'hbeef, rx_data);
        cmp("ack", 0, peer.seen[51]);
        len = build(11'h202, 1'b0, 1'b1, 4'h2, 64'h1234);
        peer.send(fb, len);
        clk(14 * BC);
        cmp("rx count", 1, n_rx);
        ack_bit = 8'd43;
        len = build({4'h5, 7'h01}, 1'b1, 1'b0, 4'h1, 64'h0);
        peer.send(fb, len);
        wait_done();
        cmp("rtr", 1, rx_rtr);
        cmp("reply id", {4'h5, 7'h01}, fld(1, 11));
        cmp("reply obj", 8'h01, fld(19, 8));
        $display("test receive done");
    endtask : t_rx
    task automatic t_bus_off();
        ack_bit = 8'd0;
        dlc = 4'h0;
        rtr = 1'b1;
        req = 1'b1;
        clk(1);
        req = 1'b0;
        wait_st(ERR_WARNING);
        cmp("tec", 9'h060, tec);
        wait_st(ERR_PASSIVE);
        cmp("tec", 9'h080, tec);
        wait_st(ERR_BUS_OFF);
        cmp("tec", 9'h100, tec);
        len = 0;
        for (int i = 0; i < 400; i++)
        begin
            clk(1);
            len += (o_tx !== 1'b1);
        end
        cmp("silent", 0, len);
        ack_bit = 8'd35;
        wait_done();
        cmp("state", ERR_ACTIVE, st);
        cmp("rtr bit", 1, peer.seen[12]);
        $display("test bus off done");
    endtask : t_bus_off
    // watchdog sized well above the longest run
    initial
    begin
        #1500000;
        n_mismatch++;
        give_verdict();
    end
    initial
    begin
        repeat (5) @(posedge i_clock);
        #2;
        i_rst_n = 1'b1;
        t_reset();
        t_tx();
        t_rx();
        t_bus_off();
        give_verdict();
    end
endmodule : can_frame_error_node_tb_top
